/* adc_ctrl_pkg.sv */
package adc_ctrl_pkg;

    localparam int RES_BITS        = 12;
    localparam int EXT_CHANNELS    = 16;
    localparam int INT_CHANNELS    = 3;
    localparam int NUM_CHANNELS    = EXT_CHANNELS + INT_CHANNELS;
    localparam int CH_BITS         = 5;
    localparam logic [4:0] TEMP_SENSOR_CH  = 5'h10;
    localparam logic [4:0] INT_REF_CH      = 5'h11;
    localparam logic [4:0] BATT_MON_CH     = 5'h12;
    localparam int BATT_DIVIDE     = 2;
    localparam int SAMPLE_CYCLES   = 4;
    localparam logic [11:0] RESULT_RST     = 12'h000;
    localparam logic [11:0] THRESH_HI_RST  = 12'hFFF;
    localparam logic [11:0] THRESH_LO_RST  = 12'h000;

    typedef enum logic [1:0]
    {
        SRC_REGULAR,
        SRC_INJECTED
    } conv_src_t;

    typedef struct packed
    {
        logic [11:0] data;
        logic [4:0]  channel;
        logic        injected;
        logic        end_of_seq;
    } result_t;

    typedef struct packed
    {
        logic        scan_mode;
        logic [18:0] scan_group;
        logic [4:0]  single_channel;
        logic [4:0]  injected_channel;
        logic        trig_regular_en;
        logic        trig_injected_en;
        logic [7:0]  trig_delay;
        logic        wdg_en;
        logic [18:0] wdg_channels;
        logic [11:0] wdg_low;
        logic [11:0] wdg_high;
    } config_t;

endpackage

/* result_buffer.sv */
`timescale 1ns/100ps
`default_nettype none

module result_buffer
    import adc_ctrl_pkg::*;
#(
    parameter int DEPTH = 2
)
(
    input  wire logic    core_clk_i,
    input  wire logic    rstn_i,
    input  wire logic    in_valid_i,
    output logic         in_ready_o,
    input  wire result_t in_data_i,
    output logic         out_valid_o,
    input  wire logic    out_ready_i,
    output result_t      out_data_o
);
    // the push and pop steering below is written for exactly two places
    if (DEPTH != 2)
    begin
        $error("result_buffer supports only DEPTH 2");
    end

    result_t     mem_q [2];
    result_t     mem_d [2];
    logic [1:0]  count_q;
    logic [1:0]  count_d;
    logic        push;
    logic        pop;

    assign in_ready_o  = (count_q != 2'h2);
    assign out_valid_o = (count_q != 2'h0);
    assign out_data_o  = mem_q[0];
    assign push        = in_valid_i && in_ready_o;
    assign pop         = out_valid_o && out_ready_i;

    always_comb
    begin
        mem_d[0] = mem_q[0];
        mem_d[1] = mem_q[1];
        count_d  = count_q;
        if (pop)
        begin
            mem_d[0] = mem_q[1];
        end
        if (push)
        begin
            if (count_q == 2'h0 || (count_q == 2'h1 && pop))
                mem_d[0] = in_data_i;
            else if (pop)
                mem_d[0] = mem_q[1];
            if ((count_q == 2'h1 && !pop) || (count_q == 2'h2 && pop))
                mem_d[1] = in_data_i;
        end
        count_d = count_q + {1'b0, push} - {1'b0, pop};
    end

    always_ff @(posedge core_clk_i)
    begin
        if (!rstn_i)
        begin
            mem_q[0] <= '0;
            mem_q[1] <= '0;
            count_q  <= 2'h0;
        end
        else
        begin
            mem_q[0] <= mem_d[0];
            mem_q[1] <= mem_d[1];
            count_q  <= count_d;
        end
    end

endmodule

`default_nettype wire

/* sar_adc_sequencer_control.sv */
`timescale 1ns/100ps
`default_nettype none

// Contract
// [RULE_01] 12-bit results by successive approximation
// [RULE_02] 16 external plus 3 internal channels
// [RULE_03] single-shot and scan group modes
// [RULE_04] each result handed to dma
// [RULE_05] watchdog flags results outside thresholds
// [RULE_06] timer events start regular and injected
// [RULE_07] channels 16,17,18 select internal sources
// [RULE_08] battery channel reads half battery voltage
// [RULE_09] shared trigger starts now or delayed
// [RULE_10] end-of-conversion and end-of-sequence flags
// [RULE_11] consuming a result clears pending data
module sar_adc_sequencer_control
    import adc_ctrl_pkg::*;
(
    input  wire logic        core_clk_i,
    input  wire logic        rstn_i,
    input  wire config_t     cfg_i,
    input  wire logic        sw_start_i,
    input  wire logic        timer_regular_trig_i,
    input  wire logic        timer_injected_trig_i,
    input  wire logic        shared_trig_i,
    output logic [4:0]       mux_channel_o,
    output logic             mux_sel_temp_sensor_o,
    output logic             mux_sel_internal_ref_o,
    output logic             mux_sel_battery_monitor_o,
    output logic             sample_o,
    output logic [11:0]      dac_trial_o,
    input  wire logic        comparator_i,
    output logic             dma_valid_o,
    input  wire logic        dma_ready_i,
    input  wire logic        sw_read_i,
    output result_t          result_o,
    output logic             data_pending_o,
    output logic             eoc_o,
    output logic             eos_o,
    output logic             wdg_irq_o,
    input  wire logic        wdg_clear_i,
    output logic             busy_o
);
    typedef enum logic [2:0]
    {
        ST_IDLE,
        ST_DELAY,
        ST_SAMPLE,
        ST_CONVERT,
        ST_STORE
    } state_t;

    function automatic logic [4:0] next_in_group(input logic [18:0] grp, input logic [4:0] cur);
        logic [4:0] res;
        res = 5'h1F;
        for (int i = NUM_CHANNELS - 1; i >= 0; i--)
        begin
            if (grp[i] && 5'(i) > cur)
                res = 5'(i);
        end
        return res;
    endfunction

    state_t       state_q, state_d;
    logic [4:0]   chan_q, chan_d;
    logic [11:0]  sar_q, sar_d;
    logic [3:0]   bit_q, bit_d;
    logic [7:0]   cnt_q, cnt_d;
    logic         inj_q, inj_d;
    logic         inj_pend_q, inj_pend_d;
    logic         eoc_q, eoc_d;
    logic         eos_q, eos_d;
    logic         wdg_q, wdg_d;
    logic         cmp_s1_q, cmp_s2_q;
    logic         push_valid;
    logic         push_ready;
    result_t      push_data;
    logic         last_of_seq;
    logic [4:0]   first_scan;
    logic         reg_start;
    logic         out_valid;
    logic         pop;

    // comparator comes from the analog domain
    always_ff @(posedge core_clk_i)
    begin
        if (!rstn_i)
        begin
            cmp_s1_q <= 1'b0;
            cmp_s2_q <= 1'b0;
        end
        else
        begin
            cmp_s1_q <= comparator_i;
            cmp_s2_q <= cmp_s1_q;
        end
    end

    // channel 0 cannot be found by a strictly-greater search, so test it first
    assign first_scan  = cfg_i.scan_group[0] ? 5'h00 : next_in_group(cfg_i.scan_group, 5'h00);
    assign reg_start   = sw_start_i || (cfg_i.trig_regular_en && timer_regular_trig_i) // [RULE_06]
                       || shared_trig_i; // [RULE_09]
    assign last_of_seq = !inj_q
                       && (!cfg_i.scan_mode || next_in_group(cfg_i.scan_group, chan_q) == 5'h1F);

    always_comb
    begin
        state_d    = state_q;
        chan_d     = chan_q;
        sar_d      = sar_q;
        bit_d      = bit_q;
        cnt_d      = cnt_q;
        inj_d      = inj_q;
        inj_pend_d = inj_pend_q || (cfg_i.trig_injected_en && timer_injected_trig_i); // [RULE_06]
        eoc_d      = 1'b0;
        eos_d      = 1'b0;
        wdg_d      = wdg_q && !wdg_clear_i;
        push_valid = 1'b0;
        case (state_q)
            ST_IDLE:
            begin
                if (inj_pend_q)
                begin
                    // a trigger arriving while the last one is served is kept
                    inj_pend_d = cfg_i.trig_injected_en && timer_injected_trig_i; // [RULE_06]
                    inj_d      = 1'b1;
                    chan_d     = cfg_i.injected_channel;
                    cnt_d      = 8'(SAMPLE_CYCLES);
                    state_d    = ST_SAMPLE;
                end
                else if (reg_start)
                begin
                    inj_d   = 1'b0;
                    // scan walks the group from its lowest channel [RULE_03]
                    chan_d  = cfg_i.scan_mode ? first_scan : cfg_i.single_channel;
                    // shared trigger may be held off by a delay [RULE_09]
                    cnt_d   = (shared_trig_i && cfg_i.trig_delay != 8'h00)
                            ? cfg_i.trig_delay : 8'(SAMPLE_CYCLES);
                    state_d = (shared_trig_i && cfg_i.trig_delay != 8'h00) ? ST_DELAY : ST_SAMPLE;
                end
            end
            ST_DELAY:
            begin
                cnt_d = cnt_q - 8'h01;
                if (cnt_q == 8'h01)
                begin
                    cnt_d   = 8'(SAMPLE_CYCLES);
                    state_d = ST_SAMPLE;
                end
            end
            ST_SAMPLE:
            begin
                cnt_d = cnt_q - 8'h01;
                if (cnt_q == 8'h01)
                begin
                    sar_d   = 12'h800;
                    bit_d   = 4'(RES_BITS - 1);
                    state_d = ST_CONVERT;
                end
            end
            ST_CONVERT:
            begin
                // comparator high means trial above input: drop the bit [RULE_01]
                if (cnt_q[1:0] == 2'h2)
                begin
                    if (cmp_s2_q)
                        sar_d[bit_q] = 1'b0;
                    if (bit_q == 4'h0)
                        state_d = ST_STORE;
                    else
                    begin
                        sar_d[bit_q - 4'h1] = 1'b1;
                        bit_d = bit_q - 4'h1;
                    end
                    cnt_d = 8'h00;
                end
                else
                    cnt_d = cnt_q + 8'h01;
            end
            ST_STORE:
            begin
                push_valid = 1'b1;
                if (push_ready)
                begin
                    eoc_d = 1'b1; // [RULE_10]
                    eos_d = last_of_seq && cfg_i.scan_mode; // [RULE_10]
                    if (cfg_i.wdg_en && cfg_i.wdg_channels[chan_q]
                        && (sar_q < cfg_i.wdg_low || sar_q > cfg_i.wdg_high))
                        wdg_d = 1'b1; // [RULE_05]
                    if (last_of_seq || inj_q)
                        state_d = ST_IDLE;
                    else
                    begin
                        chan_d  = next_in_group(cfg_i.scan_group, chan_q);
                        cnt_d   = 8'(SAMPLE_CYCLES);
                        state_d = ST_SAMPLE;
                    end
                end
            end
            default:
                state_d = ST_IDLE;
        endcase
    end

    always_ff @(posedge core_clk_i)
    begin
        if (!rstn_i)
        begin
            state_q    <= ST_IDLE;
            chan_q     <= 5'h00;
            sar_q      <= RESULT_RST;
            bit_q      <= 4'h0;
            cnt_q      <= 8'h00;
            inj_q      <= 1'b0;
            inj_pend_q <= 1'b0;
            eoc_q      <= 1'b0;
            eos_q      <= 1'b0;
            wdg_q      <= 1'b0;
        end
        else
        begin
            state_q    <= state_d;
            chan_q     <= chan_d;
            sar_q      <= sar_d;
            bit_q      <= bit_d;
            cnt_q      <= cnt_d;
            inj_q      <= inj_d;
            inj_pend_q <= inj_pend_d;
            eoc_q      <= eoc_d;
            eos_q      <= eos_d;
            wdg_q      <= wdg_d;
        end
    end

    // battery channel already carries half the battery voltage [RULE_08]
    assign push_data.data       = sar_q;
    assign push_data.channel    = chan_q;
    assign push_data.injected   = inj_q;
    assign push_data.end_of_seq = last_of_seq && cfg_i.scan_mode;

    result_buffer #(.DEPTH(2)) result_buffer_inst
    (
        .core_clk_i  (core_clk_i),
        .rstn_i      (rstn_i),
        .in_valid_i  (push_valid),
        .in_ready_o  (push_ready),
        .in_data_i   (push_data),
        .out_valid_o (out_valid),
        .out_ready_i (pop),
        .out_data_o  (result_o)
    );

    // dma or software consumes each result once [RULE_04] [RULE_11]
    assign pop            = dma_ready_i || sw_read_i;
    assign dma_valid_o    = out_valid;
    assign data_pending_o = out_valid;

    assign mux_channel_o             = chan_q; // [RULE_02]
    assign mux_sel_temp_sensor_o     = (chan_q == TEMP_SENSOR_CH); // [RULE_07]
    assign mux_sel_internal_ref_o    = (chan_q == INT_REF_CH); // [RULE_07]
    assign mux_sel_battery_monitor_o = (chan_q == BATT_MON_CH); // [RULE_07]
    assign sample_o                  = (state_q == ST_SAMPLE);
    assign dac_trial_o               = sar_q;
    assign eoc_o                     = eoc_q;
    assign eos_o                     = eos_q;
    assign wdg_irq_o                 = wdg_q;
    assign busy_o                    = (state_q != ST_IDLE);

    AST_CHAN_RANGE: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
        busy_o && state_q != ST_DELAY |-> chan_q < 5'(NUM_CHANNELS)) // [RULE_02]
        else $error("channel out of range");
    AST_EOC_AFTER_STORE: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
        eoc_q |-> $past(state_q) == ST_STORE && $past(push_ready)) // [RULE_10]
        else $error("eoc without stored result");
    AST_EOS_ONLY_SCAN: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
        eos_q |-> eoc_q && cfg_i.scan_mode) // [RULE_10]
        else $error("eos outside scan");
    AST_SAR_START: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
        state_q == ST_SAMPLE && state_d == ST_CONVERT |=> sar_q == 12'h800) // [RULE_01]
        else $error("sar did not start mid scale");
    AST_TEMP_SEL: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
        mux_sel_temp_sensor_o |-> mux_channel_o == 5'h10) // [RULE_07]
        else $error("temperature select mismatch");
    AST_WDG_STICKY: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
        wdg_q && !wdg_clear_i |=> wdg_q) // [RULE_05]
        else $error("watchdog flag lost");
    AST_DMA_PENDING: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
        dma_valid_o |-> data_pending_o) // [RULE_04]
        else $error("dma valid without pending data");
    AST_SINGLE_DONE: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
        state_q == ST_STORE && push_ready && !cfg_i.scan_mode |=> state_q == ST_IDLE) // [RULE_03]
        else $error("single shot did not stop");
    AST_DELAY_HOLD: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
        state_q == ST_IDLE && !inj_pend_q && shared_trig_i && cfg_i.trig_delay == 8'h01
        |=> state_q == ST_DELAY ##1 state_q == ST_SAMPLE) // [RULE_09]
        else $error("delayed start mistimed");

    COV_SINGLE: cover property (@(posedge core_clk_i) eoc_q && !cfg_i.scan_mode);
    COV_SCAN_END: cover property (@(posedge core_clk_i) eos_q);
    COV_INJECTED: cover property (@(posedge core_clk_i) eoc_q && inj_q);
    COV_WDG: cover property (@(posedge core_clk_i) $rose(wdg_q));

endmodule

`default_nettype wire

/* sar_core_model.sv */
`timescale 1ns/100ps
`default_nettype none

module sar_core_model
    import adc_ctrl_pkg::*;
(
    input  wire logic              core_clk_i,
    input  wire logic [4:0]        mux_channel_i,
    input  wire logic              sel_temp_i,
    input  wire logic              sel_ref_i,
    input  wire logic              sel_batt_i,
    input  wire logic              sample_i,
    input  wire logic [11:0]       dac_trial_i,
    input  wire logic [17:0][11:0] level_i,
    input  wire logic [12:0]       batt_i,
    output logic                   comparator_o
);
    logic [11:0] held = 12'h000;

    // the hold capacitor follows the input only while sampling
    always_ff @(posedge core_clk_i)
    begin
        if (sample_i)
        begin
            if (sel_batt_i)
                held <= batt_i[12:1];
            else if (sel_temp_i)
                held <= level_i[16];
            else if (sel_ref_i)
                held <= level_i[17];
            else
                held <= level_i[mux_channel_i[3:0]];
        end
    end

    // high means the trial word lies above the held input
    assign comparator_o = (dac_trial_i > held);
endmodule

`default_nettype wire

/* sar_adc_sequencer_control_bench.sv */
`timescale 1ns/100ps
`default_nettype none

module sar_adc_sequencer_control_bench;
    import adc_ctrl_pkg::*;

    logic              core_clk, rstn, comp, irq, busy, eoc, eos, pending;
    logic              sw_start, treg, tinj, tsh, dma_ready, sw_read, wdg_clear;
    logic              s_temp, s_ref, s_batt, sample, dma_valid;
    logic [4:0]        mux_ch;
    logic [11:0]       trial;
    config_t           cfg;
    result_t           res;
    logic [17:0][11:0] level;
    logic [12:0]       batt;
    int                err_total, cmp_count;

    sar_adc_sequencer_control sar_adc_sequencer_control_inst (
        .core_clk_i(core_clk), .rstn_i(rstn), .cfg_i(cfg), .sw_start_i(sw_start),
        .timer_regular_trig_i(treg), .timer_injected_trig_i(tinj), .shared_trig_i(tsh),
        .mux_channel_o(mux_ch), .mux_sel_temp_sensor_o(s_temp),
        .mux_sel_internal_ref_o(s_ref), .mux_sel_battery_monitor_o(s_batt),
        .sample_o(sample), .dac_trial_o(trial), .comparator_i(comp),
        .dma_valid_o(dma_valid), .dma_ready_i(dma_ready), .sw_read_i(sw_read),
        .result_o(res), .data_pending_o(pending), .eoc_o(eoc), .eos_o(eos),
        .wdg_irq_o(irq), .wdg_clear_i(wdg_clear), .busy_o(busy));

    sar_core_model sar_core_model_inst (
        .core_clk_i(core_clk), .mux_channel_i(mux_ch), .sel_temp_i(s_temp),
        .sel_ref_i(s_ref), .sel_batt_i(s_batt), .sample_i(sample),
        .dac_trial_i(trial), .level_i(level), .batt_i(batt), .comparator_o(comp));

    always #5 core_clk = ~core_clk;

    task automatic stop_test();
        $display("comparisons %0d, mismatches %0d", cmp_count, err_total);
        if (err_total == 0 && cmp_count > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    task automatic cmp_bit(input logic got, input logic exp, input string what);
        cmp_count++;
        if (got !== exp)
        begin
            err_total++;
            $display("unexpected at %0t: %s is %b", $time, what, got);
        end
    endtask

    task automatic cmp_word(input logic [11:0] got, input logic [11:0] exp, input string what);
        cmp_count++;
        if (got !== exp)
        begin
            err_total++;
            $display("unexpected at %0t: %s %h not %h", $time, what, got, exp);
        end
    endtask

    task automatic cyc(input int n);
        repeat (n) @(negedge core_clk);
    endtask

    // one-cycle pulse on the chosen input, launched on a falling edge
    task automatic fire(input int k);
        @(negedge core_clk);
        case (k)
            0: sw_start = 1'b1;
            1: treg = 1'b1;
            2: tinj = 1'b1;
            3: tsh = 1'b1;
            4: wdg_clear = 1'b1;
            default: sw_read = 1'b1;
        endcase
        @(negedge core_clk);
        {sw_start, treg, tinj, tsh, wdg_clear, sw_read} = 6'h00;
    endtask

    task automatic wait_eoc(output logic seen_eos);
        int n;
        n = 0;
        do
        begin
            @(posedge core_clk);
            #1;
            n++;
        end while (eoc !== 1'b1 && n < 300);
        cmp_bit(eoc, 1'b1, "end of conversion");
        seen_eos = eos;
    endtask

    function automatic logic [11:0] expv(input logic [4:0] ch);
        return (ch == 5'h12) ? batt[12:1] : level[ch];
    endfunction

    task automatic pop(input logic [4:0] ch);
        cmp_bit(dma_valid, 1'b1, "dma valid");
        cmp_word({7'h00, res.channel}, {7'h00, ch}, "channel");
        cmp_word(res.data, expv(ch), "data");
        @(negedge core_clk);
        dma_ready = 1'b1;
        @(negedge core_clk);
        dma_ready = 1'b0;
    endtask

    task automatic t_single(input logic [4:0] ch);
        logic e;
        int n;
        @(negedge core_clk);
        cfg.scan_mode = 1'b0;
        cfg.single_channel = ch;
        fire(0);
        n = 0;
        while (sample !== 1'b1 && n < 20)
        begin
            @(negedge core_clk);
            n++;
        end
        cmp_word({7'h00, mux_ch}, {7'h00, ch}, "selected channel");
        cmp_bit(s_temp, ch == 5'h10, "temp select");
        cmp_bit(s_ref, ch == 5'h11, "reference select");
        cmp_bit(s_batt, ch == 5'h12, "battery select");
        wait_eoc(e);
        pop(ch);
        $display("single shot channel %0d done", ch);
    endtask

    // three results against two buffer places: the third store must wait
    task automatic t_scan();
        logic e;
        @(negedge core_clk);
        cfg.scan_mode = 1'b1;
        cfg.scan_group = 19'h50008;
        fire(0);
        wait_eoc(e);
        cmp_bit(e, 1'b0, "early sequence end");
        wait_eoc(e);
        cmp_bit(e, 1'b0, "early sequence end");
        cyc(100);
        cmp_bit(busy, 1'b1, "busy while stalled");
        pop(5'h03);
        wait_eoc(e);
        cmp_bit(e, 1'b1, "sequence end");
        pop(5'h10);
        pop(5'h12);
        cfg.scan_mode = 1'b0;
        $display("scan with stall done");
    endtask

    task automatic t_timer();
        logic e;
        @(negedge core_clk);
        cfg.single_channel = 5'h07;
        cfg.trig_regular_en = 1'b1;
        fire(1);
        wait_eoc(e);
        cmp_bit(res.injected, 1'b0, "regular marked injected");
        pop(5'h07);
        cfg.trig_injected_en = 1'b1;
        cfg.injected_channel = 5'h09;
        fire(2);
        wait_eoc(e);
        cmp_bit(res.injected, 1'b1, "injected mark");
        pop(5'h09);
        cfg.trig_regular_en = 1'b0;
        fire(1);
        cyc(10);
        cmp_bit(busy, 1'b0, "disabled timer started");
        $display("timer triggers done");
    endtask

    task automatic start_lag(input logic [7:0] dly, output int lag);
        logic e;
        cfg.trig_delay = dly;
        fire(3);
        lag = 0;
        // busy already rises in the hold-off, so measure up to sampling
        while (sample !== 1'b1 && lag < 300)
        begin
            @(negedge core_clk);
            lag++;
        end
        wait_eoc(e);
        pop(cfg.single_channel);
    endtask

    task automatic t_shared();
        int d0, d1, d8;
        @(negedge core_clk);
        start_lag(8'h00, d0);
        start_lag(8'h01, d1);
        start_lag(8'h08, d8);
        cmp_word(12'(d1 - d0), 12'h001, "shared trigger delay");
        cmp_word(12'(d8 - d0), 12'h008, "shared trigger delay");
        $display("shared trigger done");
    endtask

    task automatic t_watch();
        logic [4:0]  chs [3] = '{5'h04, 5'h04, 5'h05};
        logic [11:0] vals [3] = '{12'h032, 12'h0C8, 12'h032};
        logic        exps [3] = '{1'b1, 1'b0, 1'b0};
        logic        e;
        @(negedge core_clk);
        cfg.wdg_en = 1'b1;
        cfg.wdg_channels = 19'h00010;
        cfg.wdg_low = 12'h064;
        cfg.wdg_high = 12'h0C8;
        for (int i = 0; i < 3; i++)
        begin
            level[chs[i]] = vals[i];
            cfg.single_channel = chs[i];
            fire(0);
            wait_eoc(e);
            cyc(3);
            cmp_bit(irq, exps[i], "watchdog flag");
            fire(4);
            cmp_bit(irq, 1'b0, "flag after clear");
            pop(chs[i]);
        end
        $display("watchdog done");
    endtask

    task automatic t_read();
        logic e;
        @(negedge core_clk);
        cfg.single_channel = 5'h0F;
        fire(0);
        wait_eoc(e);
        cyc(1);
        cmp_bit(pending, 1'b1, "pending before read");
        fire(5);
        cmp_bit(pending, 1'b0, "pending after read");
        cmp_bit(dma_valid, 1'b0, "dma valid after read");
        $display("software read done");
    endtask

    initial
    begin
        core_clk = 1'b0;
        rstn = 1'b0;
        {sw_start, treg, tinj, tsh, dma_ready, sw_read, wdg_clear} = 7'h00;
        err_total = 0;
        cmp_count = 0;
        cfg = '0;
        cfg.wdg_high = 12'hFFF;
        for (int i = 0; i < 18; i++)
            level[i] = 12'(i * 12'h0F1);
        level[15] = 12'hFFF;
        level[16] = 12'h3A7;
        level[17] = 12'h5F0;
        batt = 13'h1ABC;
        cyc(16);
        rstn = 1'b1;
        cyc(2);
        cmp_bit(busy, 1'b0, "busy after reset");
        cmp_bit(eoc, 1'b0, "eoc after reset");
        cmp_bit(pending, 1'b0, "pending after reset");
        cmp_bit(irq, 1'b0, "watchdog after reset");
        cmp_word(trial, 12'h000, "trial after reset");
        t_single(5'h00);
        t_single(5'h0F);
        t_single(5'h10);
        t_single(5'h11);
        t_single(5'h12);
        t_scan();
        t_timer();
        t_shared();
        t_watch();
        t_read();
        stop_test();
    end

    initial
    begin
        #200000;
        err_total++;
        $display("unexpected at %0t: run did not finish", $time);
        stop_test();
    end
endmodule

`default_nettype wire
